// *** chg_defines.svh ***
/*
 * Command codes, reset values, option field positions and timing figures
 * of the charger command register bank.
 * Assumes a 10 MHz system clock; included by the package and the bank.
 */
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

// Command codes reached by Read-Word and Write-Word
`define CMD_OPTIONS     8'h12
`define CMD_CURRENT     8'h14
`define CMD_VOLTAGE     8'h15
`define CMD_INCURR      8'h3F
`define CMD_MAKER       8'hFE
`define CMD_PART        8'hFF

// Power-on values
`define RST_OPTIONS     16'hF902
`define RST_CURRENT     16'h0000
`define RST_VOLTAGE     16'h0000
`define RST_INCURR      16'h1000

// Option word field positions
`define OPT_DEGL        15
`define OPT_WDT_HI      14
`define OPT_WDT_LO      13
`define OPT_DEPL_HI     12
`define OPT_DEPL_LO     11
`define OPT_FDIR        10
`define OPT_FEN         9
`define OPT_LEARN       6
`define OPT_ACIND       4

// Timing and analog figures
`define CLK_HZ          10000000
`define DEGL_SHORT_MS   150
`define DEGL_LONG_MS    1300
`define WDT_P1_S        44
`define WDT_P2_S        88
`define WDT_P3_S        175
`define DEPL_HYST_MV    9'd340
`define FREQ_TRIM_PCT   18
`define DEPL_BP_0       13'd5919
`define DEPL_BP_1       13'd6265
`define DEPL_BP_2       13'd6655
`define DEPL_BP_3       13'd7097

`endif

// *** chg_pkg.sv ***
/*
 * Types shared by the charger command register bank and its SMBus slave.
 * Assumes chg_defines.svh is reachable on the include path.
 */
`default_nettype none
`include "chg_defines.svh"

package chg_pkg;

   // SMBus slave transaction phases
   typedef enum logic [2:0] {
      BS_IDLE, BS_ADDR, BS_CMD, BS_DATLO, BS_DATHI, BS_RDLO, BS_RDHI, BS_DONE
   } chg_bus_state_t;

   typedef struct packed {
      chg_bus_state_t state;
      logic [7:0]     shift;
      logic [3:0]     bitCnt;
      logic [7:0]     cmd;
      logic [7:0]     lo;
      logic [7:0]     tx;
      logic           sdaOe;
      logic           sclPrev;
      logic           sdaPrev;
      logic           wrStb;
      logic [15:0]    wrData;
   } chg_slave_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic        flag;
   } chg_degl_t;

   typedef struct packed {
      logic [15:0] opts;
      logic [15:0] cur;
      logic [15:0] volt;
      logic [15:0] inCur;
      logic [31:0] wdCnt;
      logic        suspended;
      logic        acSw;
      logic        batSw;
      logic        acSwWasOff;
      logic [12:0] fallBp;
      logic        chgEn;
      logic        trimEn;
      logic        trimUp;
      logic        deplEn;
   } chg_bank_t;

   // Only the six charger commands are acknowledged
   function automatic logic chg_cmd_known(input logic [7:0] c);
      return (c == `CMD_OPTIONS) || (c == `CMD_CURRENT) || (c == `CMD_VOLTAGE) ||
             (c == `CMD_INCURR) || (c == `CMD_MAKER) || (c == `CMD_PART);
   endfunction

endpackage

`default_nettype wire

// *** chg_regbus_if.sv ***
/*
 * Word-level register path between the SMBus slave and the register bank.
 * Assumes both ends run on mclk; rdData is combinational from the bank.
 */
`timescale 1ns/1ps
`default_nettype none

interface chg_regbus_if;
   logic        wrStb;   // One-cycle pulse per finished Write-Word
   logic [7:0]  cmd;     // Command code of the current transaction
   logic [15:0] wrData;
   logic [15:0] rdData;

   modport slave (output wrStb, output cmd, output wrData, input rdData);
   modport bank  (input wrStb, input cmd, input wrData, output rdData);
endinterface

`default_nettype wire

// *** chg_smbus_slave.sv ***
/*
 * SMBus slave for Read-Word and Write-Word on open-drain SDA.
 * Assumes SCL and SDA are already synchronous to mclk and slow against it.
 */
`timescale 1ns/1ps
`default_nettype none

module chg_smbus_slave
   import chg_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h0A
) (
   // Clock and reset
   input  wire logic   mclk,
   input  wire logic   reset_n,
   // SMBus pins
   input  wire logic   sclIn,
   input  wire logic   sdaIn,
   output logic        sdaOe,
   // Word path to the bank
   chg_regbus_if.slave bus
);

   chg_slave_t s_r;
   chg_slave_t s_nxt;
   logic       sclRise;
   logic       sclFall;
   logic       startCond;
   logic       stopCond;

   assign sclRise   = sclIn & ~s_r.sclPrev;
   assign sclFall   = ~sclIn & s_r.sclPrev;
   assign startCond = s_r.sclPrev & sclIn & s_r.sdaPrev & ~sdaIn;
   assign stopCond  = s_r.sclPrev & sclIn & ~s_r.sdaPrev & sdaIn;

   // Byte framing; a repeated start keeps the command for Read-Word
   always_comb begin
      s_nxt = s_r;
      s_nxt.wrStb = 1'b0;
      s_nxt.sclPrev = sclIn;
      s_nxt.sdaPrev = sdaIn;
      if (startCond) begin
         s_nxt.state = BS_ADDR;
         s_nxt.bitCnt = 4'h0;
         s_nxt.sdaOe = 1'b0;
      end else if (stopCond) begin
         s_nxt.state = BS_IDLE;
         s_nxt.bitCnt = 4'h0;
         s_nxt.sdaOe = 1'b0;
      end else if (s_r.state != BS_IDLE && sclRise) begin
         if (s_r.bitCnt < 4'h8) begin
            s_nxt.shift = {s_r.shift[6:0], sdaIn};
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
         end else if (s_r.bitCnt == 4'h8) begin
            // Ack clock: master answer decides whether a second byte goes out;
            // our own address ack (sdaOe high) must not load the high byte early
            s_nxt.bitCnt = 4'h9;
            if (s_r.state == BS_RDLO && !s_r.sdaOe) begin
               s_nxt.state = sdaIn ? BS_DONE : BS_RDHI;
               s_nxt.tx = bus.rdData[15:8];
            end else if (s_r.state == BS_RDHI) begin
               s_nxt.state = BS_DONE;
            end
         end
      end else if (s_r.state != BS_IDLE && sclFall) begin
         if (s_r.bitCnt == 4'h8) begin
            s_nxt.sdaOe = 1'b0;
            case (s_r.state)
               BS_ADDR: begin
                  if (s_r.shift[7:1] == SLAVE_ADDR) begin
                     s_nxt.sdaOe = 1'b1;
                     s_nxt.state = s_r.shift[0] ? BS_RDLO : BS_CMD;
                     s_nxt.tx = bus.rdData[7:0];
                  end else begin
                     s_nxt.state = BS_IDLE;
                  end
               end
               BS_CMD: begin
                  // Unknown commands are not acknowledged
                  if (chg_cmd_known(s_r.shift)) begin
                     s_nxt.sdaOe = 1'b1;
                     s_nxt.cmd = s_r.shift;
                     s_nxt.state = BS_DATLO;
                  end else begin
                     s_nxt.state = BS_IDLE;
                  end
               end
               BS_DATLO: begin
                  s_nxt.sdaOe = 1'b1;
                  s_nxt.lo = s_r.shift;
                  s_nxt.state = BS_DATHI;
               end
               BS_DATHI: begin
                  s_nxt.sdaOe = 1'b1;
                  s_nxt.wrStb = 1'b1;
                  s_nxt.wrData = {s_r.shift, s_r.lo};
                  s_nxt.state = BS_DONE;
               end
               default: begin
                  s_nxt.sdaOe = 1'b0;
               end
            endcase
         end else if (s_r.bitCnt == 4'h9) begin
            // Release ack, or put out the first data bit of a read byte
            s_nxt.bitCnt = 4'h0;
            if (s_r.state == BS_RDLO || s_r.state == BS_RDHI) begin
               s_nxt.sdaOe = ~s_r.tx[7];
               s_nxt.tx = {s_r.tx[6:0], 1'b0};
            end else begin
               s_nxt.sdaOe = 1'b0;
            end
         end else if (s_r.bitCnt != 4'h0 &&
                      (s_r.state == BS_RDLO || s_r.state == BS_RDHI)) begin
            s_nxt.sdaOe = ~s_r.tx[7];
            s_nxt.tx = {s_r.tx[6:0], 1'b0};
         end
      end
   end

   // State register; idle bus levels are high
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{state: BS_IDLE, shift: 8'h00, bitCnt: 4'h0, cmd: 8'h00, lo: 8'h00,
                  tx: 8'h00, sdaOe: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1,
                  wrStb: 1'b0, wrData: 16'h0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sdaOe      = s_r.sdaOe;
   assign bus.wrStb  = s_r.wrStb;
   assign bus.cmd    = s_r.cmd;
   assign bus.wrData = s_r.wrData;

endmodule

`default_nettype wire

// *** chg_deglitch.sv ***
/*
 * Rising-edge deglitch of the adapter-good flag; falling edges pass at once.
 * Assumes the adapter-present level is synchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module chg_deglitch
   import chg_pkg::*;
#(
   parameter logic [31:0] SHORT_CYC = 32'd1500000,
   parameter logic [31:0] LONG_CYC  = 32'd13000000
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // Level and time choice
   input  wire logic levelIn,
   input  wire logic useLong,
   // Filtered flag
   output logic      flagOut
);

   chg_degl_t d_r;
   chg_degl_t d_nxt;
   logic [31:0] limit;

   // The window is chosen while counting, so a late option change still applies
   assign limit = useLong ? LONG_CYC : SHORT_CYC;

   always_comb begin
      d_nxt = d_r;
      if (!levelIn) begin
         d_nxt.cnt = 32'h0;
         d_nxt.flag = 1'b0;
      end else if (!d_r.flag) begin
         if (d_r.cnt >= limit - 32'h1) begin
            d_nxt.flag = 1'b1;
            d_nxt.cnt = 32'h0;
         end else begin
            d_nxt.cnt = d_r.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         d_r <= '{cnt: 32'h0, flag: 1'b0};
      end else begin
         d_r <= d_nxt;
      end
   end

   assign flagOut = d_r.flag;

endmodule

`default_nettype wire

// *** chg_charger_regs.sv ***
/*
 * Charger command register bank: options, current and voltage settings,
 * identification words, write watchdog, calibration discharge control.
 * Assumes analog comparators deliver adapter presence and battery depletion
 * as levels synchronous to mclk; the SMBus wire is resolved outside.
 */
//
// Contract
// - Six commands, each reached by SMBus Read-Word or Write-Word.
// - Two identification commands read-only, always return fixed maker and part codes.
// - 16-bit options word at 0x12, host writable, powers on 0xF902.
// - Charge-current setting at 0x14, read/write, powers on zero.
// - Charge-voltage setting at 0x15, read/write, powers on zero.
// - Input-current setting at 0x3F, read/write, powers on 0x1000.
// - First adapter insertion after reset always uses 150 ms deglitch.
// - Bit 15 picks 150 ms or 1.3 s after adapter switch turned off once.
// - Bits 14:13 pick watchdog: off, 44 s, 88 s, 175 s default.
// - Enabled watchdog suspends charging without timely current or voltage write.
// - Next current or voltage write resumes charging after watchdog suspension.
// - Depleted battery in discharge cycle: battery switch off, adapter switch on.
// - Bits 12:11 pick falling depletion threshold 59.19 to 70.97 percent.
// - Depletion comparator releases 340 mV above the falling threshold.
// - Zero charge-voltage setting disables depletion protection.
// - Bit 10 trims frequency down 18 percent at 0, up at 1.
// - Bit 9 enables frequency trim; 0 keeps nominal frequency.
// - Bit 6 starts discharge, self-clears when done, writing 0 stops it.
`timescale 1ns/1ps
`default_nettype none
`include "chg_defines.svh"

module chg_charger_regs
   import chg_pkg::*;
#(
   parameter logic [15:0] MAKER_ID  = 16'h00A5,  // Arbitrary value
   parameter logic [15:0] PART_ID   = 16'h0123,  // Arbitrary value
   parameter logic [6:0]  SLAVE_ADDR = 7'h0A,
   parameter logic [31:0] DEGL_SHORT_CYC = 32'(`DEGL_SHORT_MS * 64'd`CLK_HZ / 64'd1000),
   parameter logic [31:0] DEGL_LONG_CYC  = 32'(`DEGL_LONG_MS * 64'd`CLK_HZ / 64'd1000),
   parameter logic [31:0] WDT_P1_CYC = 32'(`WDT_P1_S * 64'd`CLK_HZ),
   parameter logic [31:0] WDT_P2_CYC = 32'(`WDT_P2_S * 64'd`CLK_HZ),
   parameter logic [31:0] WDT_P3_CYC = 32'(`WDT_P3_S * 64'd`CLK_HZ)
) (
   // Clock and reset
   input  wire logic  mclk,
   input  wire logic  reset_n,
   // SMBus pins, SDA open-drain
   input  wire logic  sclIn,
   input  wire logic  sdaIn,
   output logic       sdaOut,
   output logic       sdaOe,
   // Analog comparator levels
   input  wire logic  adapterPresent,
   input  wire logic  batteryBelowDepletion,
   // Power path and charge control
   output logic       adapterGoodFlag,
   output logic       adapterSwitchOn,
   output logic       batterySwitchOn,
   output logic       chargeEnable,
   output logic       chargeSuspended,
   // Settings to the analog loops
   output logic [15:0] chargerOptions,
   output logic [15:0] chargeCurrentSetting,
   output logic [15:0] chargeVoltageSetting,
   output logic [15:0] inputCurrentSetting,
   output logic [12:0] depletionFallBp,
   output logic [8:0]  depletionHystMv,
   output logic        depletionEnable,
   output logic        freqTrimEnable,
   output logic        freqTrimUp
);

   chg_regbus_if bus ();
   chg_bank_t    b_r;
   chg_bank_t    b_nxt;
   logic         goodFlag;
   logic         wrOpt;
   logic         wrSetpoint;
   logic         learnDone;
   logic [31:0]  wdLimit;

   // Watchdog period in cycles for the 2-bit field
   function automatic logic [31:0] wdt_period(input logic [1:0] sel);
      case (sel)
         2'h1:    return WDT_P1_CYC;
         2'h2:    return WDT_P2_CYC;
         2'h3:    return WDT_P3_CYC;
         default: return 32'h0;
      endcase
   endfunction

   // Falling depletion threshold in hundredths of a percent
   function automatic logic [12:0] depl_bp(input logic [1:0] sel);
      case (sel)
         2'h0:    return `DEPL_BP_0;
         2'h1:    return `DEPL_BP_1;
         2'h2:    return `DEPL_BP_2;
         default: return `DEPL_BP_3;
      endcase
   endfunction

   chg_smbus_slave #(
      .SLAVE_ADDR (SLAVE_ADDR)
   ) u_slave (
      .mclk    (mclk),
      .reset_n (reset_n),
      .sclIn   (sclIn),
      .sdaIn   (sdaIn),
      .sdaOe   (sdaOe),
      .bus     (bus.slave)
   );

   // Long window only once the adapter switch has turned off at least once
   chg_deglitch #(
      .SHORT_CYC (DEGL_SHORT_CYC),
      .LONG_CYC  (DEGL_LONG_CYC)
   ) u_degl (
      .mclk    (mclk),
      .reset_n (reset_n),
      .levelIn (adapterPresent),
      .useLong (b_r.acSwWasOff & b_r.opts[`OPT_DEGL]),
      .flagOut (goodFlag)
   );

   assign wrOpt      = bus.wrStb && (bus.cmd == `CMD_OPTIONS);
   assign wrSetpoint = bus.wrStb && (bus.cmd == `CMD_CURRENT || bus.cmd == `CMD_VOLTAGE);
   assign wdLimit    = wdt_period(b_r.opts[`OPT_WDT_HI:`OPT_WDT_LO]);
   // Zero voltage setting keeps the depletion comparator from ending the cycle
   assign learnDone  = b_r.opts[`OPT_LEARN] && batteryBelowDepletion &&
                       (b_r.volt != 16'h0000);

   // Read mux; the adapter indication bit shows the live level
   always_comb begin
      case (bus.cmd)
         `CMD_OPTIONS: begin
            bus.rdData = b_r.opts;
            bus.rdData[`OPT_ACIND] = adapterPresent;
         end
         `CMD_CURRENT: bus.rdData = b_r.cur;
         `CMD_VOLTAGE: bus.rdData = b_r.volt;
         `CMD_INCURR:  bus.rdData = b_r.inCur;
         `CMD_MAKER:   bus.rdData = MAKER_ID;
         `CMD_PART:    bus.rdData = PART_ID;
         default:      bus.rdData = 16'h0000;
      endcase
   end

   // Register writes, watchdog, discharge cycle and derived outputs
   always_comb begin
      b_nxt = b_r;
      // Identification commands have no storage, so their writes fall through
      if (bus.wrStb) begin
         case (bus.cmd)
            `CMD_OPTIONS: b_nxt.opts = bus.wrData;
            `CMD_CURRENT: b_nxt.cur = bus.wrData;
            `CMD_VOLTAGE: b_nxt.volt = bus.wrData;
            `CMD_INCURR:  b_nxt.inCur = bus.wrData;
            default:      b_nxt.cur = b_r.cur;
         endcase
      end
      b_nxt.opts[`OPT_ACIND] = 1'b0;
      // Host write of the learn bit wins over the hardware clear
      if (learnDone && !wrOpt) begin
         b_nxt.opts[`OPT_LEARN] = 1'b0;
      end
      // A setpoint write restarts the period and lifts any suspension
      if (wrSetpoint) begin
         b_nxt.wdCnt = 32'h0;
         b_nxt.suspended = 1'b0;
      end else if (wdLimit == 32'h0) begin
         b_nxt.wdCnt = 32'h0;
      end else if (!b_r.suspended) begin
         if (b_r.wdCnt >= wdLimit - 32'h1) begin
            b_nxt.suspended = 1'b1;
            b_nxt.wdCnt = 32'h0;
         end else begin
            b_nxt.wdCnt = b_r.wdCnt + 32'h1;
         end
      end
      // Discharge cycle runs from the battery; otherwise the adapter feeds
      b_nxt.batSw = b_nxt.opts[`OPT_LEARN];
      b_nxt.acSw = goodFlag && !b_nxt.opts[`OPT_LEARN];
      if (b_r.acSw && !b_nxt.acSw) begin
         b_nxt.acSwWasOff = 1'b1;
      end
      b_nxt.fallBp = depl_bp(b_nxt.opts[`OPT_DEPL_HI:`OPT_DEPL_LO]);
      b_nxt.deplEn = (b_nxt.volt != 16'h0000);
      b_nxt.trimEn = b_nxt.opts[`OPT_FEN];
      b_nxt.trimUp = b_nxt.opts[`OPT_FEN] & b_nxt.opts[`OPT_FDIR];
      b_nxt.chgEn = goodFlag && !b_nxt.suspended && !b_nxt.opts[0] &&
                    !b_nxt.opts[`OPT_LEARN];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         b_r <= '{opts: `RST_OPTIONS, cur: `RST_CURRENT, volt: `RST_VOLTAGE,
                  inCur: `RST_INCURR, wdCnt: 32'h0, suspended: 1'b0, acSw: 1'b0,
                  batSw: 1'b0, acSwWasOff: 1'b0, fallBp: `DEPL_BP_3, chgEn: 1'b0,
                  trimEn: 1'b0, trimUp: 1'b0, deplEn: 1'b0};
      end else begin
         b_r <= b_nxt;
      end
   end

   // Outputs straight from registers; sdaOut and depletionHystMv are constants
   assign sdaOut               = 1'b0;
   assign adapterGoodFlag      = goodFlag;
   assign adapterSwitchOn      = b_r.acSw;
   assign batterySwitchOn      = b_r.batSw;
   assign chargeEnable         = b_r.chgEn;
   assign chargeSuspended      = b_r.suspended;
   assign chargerOptions       = b_r.opts;
   assign chargeCurrentSetting = b_r.cur;
   assign chargeVoltageSetting = b_r.volt;
   assign inputCurrentSetting  = b_r.inCur;
   assign depletionFallBp      = b_r.fallBp;
   assign depletionHystMv      = `DEPL_HYST_MV;
   assign depletionEnable      = b_r.deplEn;
   assign freqTrimEnable       = b_r.trimEn;
   assign freqTrimUp           = b_r.trimUp;

   // Checks on the bank behaviour
   property p_id_read;
      @(posedge mclk) disable iff (!reset_n)
      (bus.cmd == `CMD_PART) |-> (bus.rdData == PART_ID);
   endproperty
   a_id_read: assert property (p_id_read) else $error("part code changed");

   property p_opt_write;
      @(posedge mclk) disable iff (!reset_n)
      wrOpt |=> (chargerOptions[15:7] == $past(bus.wrData[15:7]));
   endproperty
   a_opt_write: assert property (p_opt_write) else $error("options not stored");

   property p_cur_write;
      @(posedge mclk) disable iff (!reset_n)
      (bus.wrStb && bus.cmd == `CMD_CURRENT) |=>
         (chargeCurrentSetting == $past(bus.wrData)) ##1 chargeCurrentSetting == $past(bus.wrData, 2);
   endproperty
   a_cur_write: assert property (p_cur_write) else $error("current not stored");

   property p_wdt_resume;
      @(posedge mclk) disable iff (!reset_n)
      wrSetpoint |=> !chargeSuspended;
   endproperty
   a_wdt_resume: assert property (p_wdt_resume) else $error("no resume on write");

   property p_wdt_cause;
      @(posedge mclk) disable iff (!reset_n)
      $rose(chargeSuspended) |-> ($past(chargerOptions[14:13]) != 2'h0) && !$past(wrSetpoint);
   endproperty
   a_wdt_cause: assert property (p_wdt_cause) else $error("bad suspension");

   property p_wdt_off;
      @(posedge mclk) disable iff (!reset_n)
      (chargerOptions[14:13] == 2'h0 && !chargeSuspended) |=> !chargeSuspended;
   endproperty
   a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog fired");

   property p_learn_path;
      @(posedge mclk) disable iff (!reset_n)
      chargerOptions[`OPT_LEARN] |-> batterySwitchOn && !adapterSwitchOn;
   endproperty
   a_learn_path: assert property (p_learn_path) else $error("switches wrong in cycle");

   property p_learn_end;
      @(posedge mclk) disable iff (!reset_n)
      (learnDone && !wrOpt) |=> !chargerOptions[`OPT_LEARN] && !batterySwitchOn;
   endproperty
   a_learn_end: assert property (p_learn_end) else $error("cycle did not end");

   property p_depl_zero;
      @(posedge mclk) disable iff (!reset_n)
      (chargerOptions[`OPT_LEARN] && chargeVoltageSetting == 16'h0000 && !bus.wrStb)
         |=> chargerOptions[`OPT_LEARN];
   endproperty
   a_depl_zero: assert property (p_depl_zero) else $error("depletion not disabled");

   property p_trim;
      @(posedge mclk) disable iff (!reset_n)
      freqTrimUp |-> freqTrimEnable && chargerOptions[`OPT_FDIR];
   endproperty
   a_trim: assert property (p_trim) else $error("trim direction wrong");

   property p_trim_en;
      @(posedge mclk) disable iff (!reset_n)
      wrOpt |=> (freqTrimEnable == $past(bus.wrData[`OPT_FEN]));
   endproperty
   a_trim_en: assert property (p_trim_en) else $error("trim enable not applied");

   property p_maker_read;
      @(posedge mclk) disable iff (!reset_n)
      (bus.cmd == `CMD_MAKER) |-> (bus.rdData == MAKER_ID);
   endproperty
   a_maker_read: assert property (p_maker_read) else $error("maker code changed");

   c_write_word: cover property (@(posedge mclk) disable iff (!reset_n) wrSetpoint);
   c_suspend: cover property (@(posedge mclk) disable iff (!reset_n) $rose(chargeSuspended));
   c_learn_end: cover property (@(posedge mclk) disable iff (!reset_n) learnDone);

endmodule

`default_nettype wire

// *** chg_host_model.sv ***
/* SMBus host model issuing Read-Word and Write-Word transfers.
   Assumes SDA is resolved outside from both pull-downs and a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module chg_host_model #(
   parameter logic [6:0] ADDR = 7'h0A
) (
   // Clock and bus
   input  wire logic mclk,
   input  wire logic sdaIn,
   output var logic  sclOut,
   output var logic  sdaLow
);
   // Bus idle at time zero
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Data moves only while SCL is low; three cycles before SCL rises, three high, one after it falls
   task automatic bit_io(input logic b, output logic r);
      sdaLow = !b;
      cyc(3);
      sclOut = 1'b1;
      cyc(3);
      r = sdaIn;
      sclOut = 1'b0;
      cyc(1);
   endtask
   // Start or repeated start, only issued after reset is over
   task automatic start;
      sdaLow = 1'b0;
      cyc(2);
      sclOut = 1'b1;
      cyc(3);
      sdaLow = 1'b1;
      cyc(3);
      sclOut = 1'b0;
      cyc(2);
   endtask
   task automatic stop;
      sdaLow = 1'b1;
      cyc(2);
      sclOut = 1'b1;
      cyc(3);
      sdaLow = 1'b0;
      cyc(3);
   endtask
   // MSB first, then the ack bit
   task automatic byte_io(input logic [7:0] d, input logic mAck, output logic [7:0] q,
                          output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(!mAck, a);
      ack = !a;
   endtask
   // Whole word transfer, low byte first
   task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic ok);
      logic [4:0] k;
      logic [7:0] x;
      start;
      byte_io({ADDR, 1'b0}, 1'b0, x, k[0]);
      byte_io(c, 1'b0, x, k[1]);
      if (rd) begin
         start;
         byte_io({ADDR, 1'b1}, 1'b0, x, k[2]);
         byte_io(8'hFF, 1'b1, q[7:0], k[3]);
         byte_io(8'hFF, 1'b0, q[15:8], k[4]);
      end else begin
         byte_io(d[7:0], 1'b0, x, k[2]);
         byte_io(d[15:8], 1'b0, x, k[3]);
      end
      stop;
      ok = k[0] & k[1] & k[2] & (rd | k[3]);
   endtask
endmodule
`default_nettype wire

// *** chg_charger_regs_tb_top.sv ***
/* Bench for the charger command bank: power-on values, option fields,
   watchdog, deglitch, discharge. Assumes chg_host_model as bus master. */
`timescale 1ns/1ps
`default_nettype none
module chg_charger_regs_tb_top;
   logic        mclk, reset_n, present, below, sclIn, sdaLow, sdaOe, ok;
   logic        good, acSw, batSw, susp, trimEn, trimUp, deplEn, sdaOut, chgEn;
   logic [12:0] fallBp;
   logic [8:0]  hyst;
   logic [15:0] q, opts, cur, volt, inCur;
   int          error_cnt = 0;
   int          samples_checked = 0;
   logic [12:0] bp [4] = '{13'd5919, 13'd6265, 13'd6655, 13'd7097};
   wire logic   sda = !(sdaLow | sdaOe);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   chg_host_model host (.mclk(mclk), .sdaIn(sda), .sclOut(sclIn), .sdaLow(sdaLow));
   // Short counts keep the run brief
   chg_charger_regs #(.DEGL_SHORT_CYC(32'd20),
      .DEGL_LONG_CYC(32'd40), .WDT_P1_CYC(32'd2000), .WDT_P2_CYC(32'd4000),
      .WDT_P3_CYC(32'd8000)) dut (
      .mclk(mclk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .adapterPresent(present), .batteryBelowDepletion(below), .adapterGoodFlag(good),
      .adapterSwitchOn(acSw), .batterySwitchOn(batSw), .chargeEnable(chgEn),
      .chargeSuspended(susp), .chargerOptions(opts), .chargeCurrentSetting(cur),
      .chargeVoltageSetting(volt), .inputCurrentSetting(inCur), .depletionFallBp(fallBp),
      .depletionHystMv(hyst), .depletionEnable(deplEn), .freqTrimEnable(trimEn),
      .freqTrimUp(trimUp));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chb(input string n, input logic e, input logic g);
      chk(n, {15'h0, e}, {15'h0, g});
   endtask
   // Read compares d, write stores d; a is the expected ack
   task automatic acc(input logic rd, input logic [7:0] c, input logic [15:0] d, input logic a);
      host.xfer(rd, c, d, q, ok);
      chb("ack", a, ok);
      if (rd) chk("read", d, q);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      present = 1'b0;
      below   = 1'b0;
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      host.cyc(2);
      acc(1, 8'h12, 16'hF902, 1);
      acc(1, 8'h14, 16'h0000, 1);
      acc(1, 8'h15, 16'h0000, 1);
      acc(1, 8'h3F, 16'h1000, 1);
      acc(0, 8'hFE, 16'h5A5A, 1);
      acc(0, 8'hFF, 16'h5A5A, 1);
      acc(1, 8'hFE, 16'h00A5, 1);
      acc(1, 8'hFF, 16'h0123, 1);
      acc(0, 8'h13, 16'h1234, 0);
      $display("test power-on values done");
      // Every depletion code, trim code pairs riding along
      for (int k = 0; k < 4; k++) begin
         acc(0, 8'h12, {3'b100, 2'(k), k[0], k[1], 9'h000}, 1);
         chk("fallBp", {3'h0, bp[k]}, {3'h0, fallBp});
         chb("trimEn", k[1], trimEn);
         chb("trimUp", k[1] & k[0], trimUp);
      end
      chk("hyst", 16'd340, {7'h0, hyst});
      acc(0, 8'h14, 16'h1F80, 1);
      acc(1, 8'h14, 16'h1F80, 1);
      acc(0, 8'h3F, 16'h0F80, 1);
      acc(1, 8'h3F, 16'h0F80, 1);
      acc(0, 8'h15, 16'h3000, 1);
      chb("deplEn", 1'b1, deplEn);
      acc(0, 8'h15, 16'h0000, 1);
      chb("deplEn", 1'b0, deplEn);
      $display("test option fields done");
      // Shortest period; the current write restarts the count
      acc(0, 8'h12, 16'h2000, 1);
      acc(0, 8'h14, 16'h0100, 1);
      host.cyc(1800);
      chb("susp", 1'b0, susp);
      host.cyc(300);
      chb("susp", 1'b1, susp);
      acc(0, 8'h15, 16'h3000, 1);
      chb("susp", 1'b0, susp);
      $display("test watchdog done");
      acc(0, 8'h12, 16'h8000, 1);
      present = 1'b1;
      host.cyc(15);
      chb("good", 1'b0, good);
      host.cyc(10);
      chb("good", 1'b1, good);
      acc(0, 8'h12, 16'h8040, 1);
      chb("batSw", 1'b1, batSw);
      chb("acSw", 1'b0, acSw);
      below = 1'b1;
      host.cyc(3);
      chb("batSw", 1'b0, batSw);
      chb("acSw", 1'b1, acSw);
      acc(1, 8'h12, 16'h8010, 1);
      below = 1'b0;
      present = 1'b0;
      host.cyc(3);
      present = 1'b1;
      host.cyc(30);
      chb("good", 1'b0, good);
      host.cyc(15);
      chb("good", 1'b1, good);
      chb("chgEn", 1'b1, chgEn);
      chk("opts", 16'h8000, opts);
      chk("cur", 16'h0100, cur);
      chk("volt", 16'h3000, volt);
      chk("inCur", 16'h0F80, inCur);
      chb("sdaOut", 1'b0, sdaOut);
      $display("test deglitch and discharge done");
      end_of_test();
   end
endmodule
`default_nettype wire
